// file: logic/smc_supply_monitor.sv
/*
 * supply monitor: internal reset from regulator under-voltage comparators, supply
 * micro-cut abort of the response frame, capacitor-test sequencing.
 * assumes comparator inputs are asynchronous, high when voltage is good;
 * sync and transmit-done indications come from logic on core_clk.
 */
`include "smc_regs.svh"
module smc_supply_monitor
	import smc_pkg::*;
#(
	parameter smc_cnt_t ASYNC_DELAY = smc_cnt_t'(`SMC_ASYNC_DELAY_CYC),
	parameter smc_cnt_t SYNC_DELAY = smc_cnt_t'(`SMC_SYNC_DELAY_CYC),
	parameter smc_cnt_t REPEAT_INTERVAL = smc_cnt_t'(`SMC_REPEAT_INTERVAL_CYC)
)(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic supply_ok,
	input wire logic buffer_regulator_ok,
	input wire logic digital_regulator_ok,
	input wire logic analog_regulator_ok,
	input wire logic sync_mode,
	input wire logic sync_pulse,
	input wire logic tx_start,
	input wire logic tx_done,
	output logic internal_rst_b,
	output logic tx_enable,
	output logic tx_abort,
	output logic buffer_regulator_off,
	output logic digital_regulator_off,
	output logic analog_regulator_off
);
	logic [3:0] ok_meta, ok_sync;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ok_meta <= 4'h0;
			ok_sync <= 4'h0;
		end else begin
			ok_meta <= {supply_ok, buffer_regulator_ok,
				digital_regulator_ok, analog_regulator_ok};
			ok_sync <= ok_meta;
		end
	end
	logic sup_ok;
	logic regs_ok;
	assign sup_ok = ok_sync[3];
	assign regs_ok = &ok_sync[2:0];

	// internal reset; a regulator drop inside its own test window is the
	// missing-capacitor case and takes the same path
	logic rst_int, next_rst_int;
	always_comb begin
		next_rst_int = rst_int;
		if (!regs_ok)
			next_rst_int = 1'b1;
		else
			next_rst_int = 1'b0;
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			rst_int <= 1'b1;
		else
			rst_int <= next_rst_int;
	end
	logic run_b;
	assign run_b = rst_b & ~rst_int;

	// transmit state
	smc_tx_t tx_st, next_tx_st;
	logic abort_q, next_abort;
	always_comb begin
		next_tx_st = tx_st;
		next_abort = 1'b0;
		case (tx_st)
			SMC_TX_ARMED: begin
				if (!sup_ok)
					next_tx_st = SMC_TX_SILENT;
				else if (tx_start)
					next_tx_st = SMC_TX_SENDING;
			end
			SMC_TX_SENDING: begin
				if (!sup_ok) begin
					next_tx_st = SMC_TX_SILENT;
					next_abort = 1'b1;
				end else if (tx_done)
					next_tx_st = SMC_TX_ARMED;
			end
			SMC_TX_SILENT: begin
				if (sup_ok && sync_pulse)
					next_tx_st = SMC_TX_ARMED;
			end
			default: next_tx_st = SMC_TX_SILENT;
		endcase
	end
	always_ff @(posedge core_clk or negedge run_b) begin
		if (!run_b) begin
			tx_st <= SMC_TX_SILENT;
			abort_q <= 1'b0;
		end else begin
			tx_st <= next_tx_st;
			abort_q <= next_abort;
		end
	end

	// repeat interval for digital and analog tests
	smc_cnt_t rep_cnt, next_rep_cnt;
	logic rep_tick, next_rep_tick;
	always_comb begin
		next_rep_tick = 1'b0;
		if (rep_cnt <= `SMC_CNT_ONE) begin
			next_rep_cnt = REPEAT_INTERVAL;
			next_rep_tick = 1'b1;
		end else
			next_rep_cnt = rep_cnt - `SMC_CNT_ONE;
	end
	always_ff @(posedge core_clk or negedge run_b) begin
		if (!run_b) begin
			rep_cnt <= REPEAT_INTERVAL;
			rep_tick <= 1'b0;
		end else begin
			rep_cnt <= next_rep_cnt;
			rep_tick <= next_rep_tick;
		end
	end

	smc_timer_if buf_if ();
	smc_timer_if dig_if ();
	smc_timer_if ana_if ();
	assign buf_if.start = sync_mode ? sync_pulse : (tx_done &&
		tx_st == SMC_TX_SENDING);
	assign buf_if.delay = sync_mode ? SYNC_DELAY : ASYNC_DELAY;
	assign dig_if.start = rep_tick;
	assign dig_if.delay = `SMC_CNT_ONE;
	// analog follows digital by half the interval so both never drop at once
	assign ana_if.start = (rep_cnt == (REPEAT_INTERVAL >> 1));
	assign ana_if.delay = `SMC_CNT_ONE;

	smc_cap_timer u_buf (.core_clk(core_clk), .rst_b(run_b), .ctl(buf_if));
	smc_cap_timer u_dig (.core_clk(core_clk), .rst_b(run_b), .ctl(dig_if));
	smc_cap_timer u_ana (.core_clk(core_clk), .rst_b(run_b), .ctl(ana_if));

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			internal_rst_b <= 1'b0;
			tx_enable <= 1'b0;
			tx_abort <= 1'b0;
			buffer_regulator_off <= 1'b0;
			digital_regulator_off <= 1'b0;
			analog_regulator_off <= 1'b0;
		end else begin
			internal_rst_b <= ~rst_int;
			tx_enable <= (tx_st != SMC_TX_SILENT) && !rst_int;
			tx_abort <= abort_q;
			buffer_regulator_off <= buf_if.reg_off;
			digital_regulator_off <= dig_if.reg_off;
			analog_regulator_off <= ana_if.reg_off;
		end
	end

	AST_HOLD_RESET: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!regs_ok |-> ##2 !internal_rst_b)
		else $error("internal reset not asserted on low regulator");
	AST_DROP_RESET: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		$fell(ok_sync[2]) |-> ##2 !internal_rst_b)
		else $error("buffer drop did not reset");
	AST_ABORT: assert property (
		@(posedge core_clk) disable iff (!run_b)
		(tx_st == SMC_TX_SENDING && !sup_ok) |-> ##2 tx_abort)
		else $error("frame not aborted on supply cut");
	AST_ABORT_PULSE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		tx_abort |=> !tx_abort)
		else $error("abort longer than one cycle");
	AST_NO_RESET_ON_CUT: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(!sup_ok && regs_ok) |-> ##2 internal_rst_b)
		else $error("supply cut caused reset");
	AST_CUT_SILENT: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!sup_ok |-> ##2 !tx_enable)
		else $error("responses allowed during supply cut");
	AST_SILENT: assert property (
		@(posedge core_clk) disable iff (!run_b)
		(tx_st == SMC_TX_SILENT && !sync_pulse)
		|=> tx_st == SMC_TX_SILENT)
		else $error("left silence without sync");
	AST_REARM: assert property (
		@(posedge core_clk) disable iff (!run_b)
		(tx_st == SMC_TX_SILENT && sup_ok && sync_pulse)
		|=> tx_st == SMC_TX_ARMED)
		else $error("sync did not rearm");
	AST_SYNC_START: assert property (
		@(posedge core_clk) disable iff (!run_b)
		(sync_mode && sync_pulse) |-> buf_if.start)
		else $error("sync did not start buffer test");
	AST_REP_TICK: assert property (
		@(posedge core_clk) disable iff (!run_b)
		rep_tick |=> ##2 digital_regulator_off)
		else $error("digital test not started");
	AST_CAP_RESET: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(dig_if.reg_off && !ok_sync[1]) |-> ##1 rst_int)
		else $error("missing capacitor did not reset");

	COV_ABORT: cover property (@(posedge core_clk) tx_abort);
	COV_BUF_OFF: cover property (@(posedge core_clk) buffer_regulator_off);
	COV_ANA_OFF: cover property (@(posedge core_clk) analog_regulator_off);
	COV_CAP_RESET: cover property (@(posedge core_clk)
		dig_if.reg_off && rst_int);
endmodule // smc_supply_monitor

// file: logic/smc_regs.svh
/*
 * timing counts and widths for the supply monitor and capacitor test.
 * assumes core_clk at 200 MHz; counts are in core_clk cycles.
 */
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

`define SMC_CLK_PERIOD_NS 5
`define SMC_ASYNC_DELAY_NS 20000
`define SMC_SYNC_DELAY_NS 10000
`define SMC_OFF_DURATION_NS 2000
`define SMC_REPEAT_INTERVAL_NS 1000000
`define SMC_ASYNC_DELAY_CYC (`SMC_ASYNC_DELAY_NS / `SMC_CLK_PERIOD_NS)
`define SMC_SYNC_DELAY_CYC (`SMC_SYNC_DELAY_NS / `SMC_CLK_PERIOD_NS)
`define SMC_OFF_DURATION_CYC (`SMC_OFF_DURATION_NS / `SMC_CLK_PERIOD_NS)
`define SMC_REPEAT_INTERVAL_CYC (`SMC_REPEAT_INTERVAL_NS / `SMC_CLK_PERIOD_NS)
`define SMC_CNT_W 24
`define SMC_CNT_ZERO 24'h000000
`define SMC_CNT_ONE 24'h000001

`endif

// file: logic/smc_pkg.sv
/*
 * types shared by the supply monitor files.
 * assumes nothing beyond the timing header.
 */
package smc_pkg;
	typedef logic [23:0] smc_cnt_t;
	typedef enum logic [1:0] {
		SMC_IDLE,
		SMC_WAIT,
		SMC_OFF
	} smc_phase_t;
	typedef enum logic [1:0] {
		SMC_TX_ARMED,
		SMC_TX_SENDING,
		SMC_TX_SILENT
	} smc_tx_t;
endpackage

// file: logic/smc_timer_if.sv
/*
 * control and status of one capacitor-test timer.
 * assumes a single core_clk domain.
 */
interface smc_timer_if;
	import smc_pkg::*;
	logic start;
	smc_cnt_t delay;
	logic reg_off;
	modport owner (output start, output delay, input reg_off);
	modport timer (input start, input delay, output reg_off);
endinterface

// file: logic/smc_cap_timer.sv
/*
 * one capacitor-test sequencer: delay, then regulator off for a window.
 * assumes start is a one-cycle pulse on core_clk; a start while busy is
 * ignored so one test window never stretches the next.
 */
`include "smc_regs.svh"
module smc_cap_timer
	import smc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	smc_timer_if.timer ctl
);
	smc_phase_t phase, next_phase;
	smc_cnt_t cnt, next_cnt;
	logic off, next_off;

	always_comb begin
		next_phase = phase;
		next_cnt = cnt;
		next_off = 1'b0;
		case (phase)
			SMC_IDLE: begin
				if (ctl.start) begin
					next_phase = SMC_WAIT;
					next_cnt = ctl.delay;
				end
			end
			SMC_WAIT: begin
				if (cnt <= `SMC_CNT_ONE) begin
					next_phase = SMC_OFF;
					next_cnt = smc_cnt_t'(`SMC_OFF_DURATION_CYC);
					next_off = 1'b1;
				end else begin
					next_cnt = cnt - `SMC_CNT_ONE;
				end
			end
			SMC_OFF: begin
				if (cnt <= `SMC_CNT_ONE) begin
					next_phase = SMC_IDLE;
					next_cnt = `SMC_CNT_ZERO;
				end else begin
					next_cnt = cnt - `SMC_CNT_ONE;
					next_off = 1'b1;
				end
			end
			default: begin
				next_phase = SMC_IDLE;
				next_cnt = `SMC_CNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= SMC_IDLE;
			cnt <= `SMC_CNT_ZERO;
			off <= 1'b0;
		end else begin
			phase <= next_phase;
			cnt <= next_cnt;
			off <= next_off;
		end
	end

	assign ctl.reg_off = off;

	AST_OFF_WIDTH: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		$rose(off) |-> off [*8])
		else $error("test window shorter than expected");
endmodule // smc_cap_timer

// file: verif/smc_reg_model.sv
/*
 regulator and comparator model facing the supply monitor.
 assumes off requests and fault injects arrive on core_clk.
*/
module smc_reg_model (
	input wire logic core_clk,
	input wire logic power_up,
	input wire logic [2:0] reg_off,
	input wire logic [2:0] cap_ok,
	input wire logic [2:0] fault,
	output logic [2:0] reg_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	// missing cap collapses
	// a present cap holds the rail through the off window
	always_ff @(posedge core_clk) begin
		reg_ok <= {3{power_up}} & ~(reg_off & ~cap_ok) & ~fault;
	end
endmodule // smc_reg_model

// file: verif/tb_supply_monitor_captest.sv
/*
 self-checking bench for smc_supply_monitor, random and corner cases.
 assumes smc_reg_model as the regulators; short sim timing counts.
*/
module tb_supply_monitor_captest;
	timeunit 1ns;
	timeprecision 1ps;
	import smc_pkg::*;
	localparam int AD = 20;
	localparam int SD = 10;
	localparam int RI = 1000;
	localparam int OD = 400;
	logic core_clk = 1'b0, rst_b = 1'b0, supply_ok = 1'b1;
	logic sync_mode = 1'b0, pwr = 1'b0;
	logic sync_pulse = 1'b0, tx_start = 1'b0, tx_done = 1'b0;
	logic [2:0] cap_ok = 3'h7, fault = 3'h0, ok;
	wire [2:0] off;
	logic internal_rst_b, tx_enable, tx_abort;
	logic [5:0] mon;
	logic [7:0] lf = 8'h28;
	int num_errors = 0, n_checks = 0;
	// mon: 0..2 regulator off, 3 internal reset, 4 abort, 5 enable
	assign mon = {tx_enable, tx_abort, internal_rst_b, off};
	smc_supply_monitor #(.ASYNC_DELAY(24'h000014), .SYNC_DELAY(24'h00000a),
		.REPEAT_INTERVAL(24'h0003e8)) i_dut (
		.core_clk(core_clk), .rst_b(rst_b), .supply_ok(supply_ok),
		.buffer_regulator_ok(ok[0]), .digital_regulator_ok(ok[1]),
		.analog_regulator_ok(ok[2]), .sync_mode(sync_mode),
		.sync_pulse(sync_pulse), .tx_start(tx_start), .tx_done(tx_done),
		.internal_rst_b(internal_rst_b), .tx_enable(tx_enable),
		.tx_abort(tx_abort), .buffer_regulator_off(off[0]),
		.digital_regulator_off(off[1]), .analog_regulator_off(off[2]));
	smc_reg_model i_reg (.core_clk(core_clk), .power_up(pwr),
		.reg_off(off), .cap_ok(cap_ok), .fault(fault), .reg_ok(ok));
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	function automatic logic [7:0] nx(logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic int exp_dly(bit sync_m);
		return sync_m ? SD : AD;
	endfunction
	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(logic got, logic exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// cycle counts: tolerance covers sampling and register skew
	task automatic chk_n(int got, int exp);
		n_checks++;
		if (got < exp - 3 || got > exp + 3) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(int i, logic v, int lim, output int c);
		c = 0;
		while (mon[i] !== v && c < lim) begin
			@(negedge core_clk);
			c++;
		end
		if (c >= lim) begin
			num_errors++;
			final_report();
		end
	endtask
	task automatic pulse(int w);
		@(posedge core_clk);
		case (w)
			0: sync_pulse <= 1'b1;
			1: tx_start <= 1'b1;
			default: tx_done <= 1'b1;
		endcase
		@(posedge core_clk);
		{sync_pulse, tx_start, tx_done} <= 3'h0;
		@(negedge core_clk);
	endtask
	initial begin
		int c, d;
		repeat (16) @(negedge core_clk);
		chk(internal_rst_b, 1'b0);
		chk(tx_enable, 1'b0);
		@(posedge core_clk);
		rst_b <= 1'b1;
		repeat (8) @(negedge core_clk);
		chk(internal_rst_b, 1'b0);
		@(posedge core_clk);
		pwr <= 1'b1;
		wt(3, 1'b1, 12, c);
		chk_n(c, 5);
		chk(tx_enable, 1'b0);
		pulse(0);
		wt(5, 1'b1, 6, c);
		pulse(1);
		pulse(2);
		wt(0, 1'b1, 60, c);
		chk_n(c, exp_dly(1'b0));
		wt(0, 1'b0, 500, c);
		chk_n(c, OD);
		@(posedge core_clk);
		sync_mode <= 1'b1;
		pulse(0);
		wt(0, 1'b1, 40, c);
		chk_n(c, exp_dly(1'b1));
		wt(0, 1'b0, 500, c);
		chk_n(c, OD);
		pulse(1);
		@(posedge core_clk);
		supply_ok <= 1'b0;
		wt(4, 1'b1, 8, c);
		chk_n(c, 4);
		@(negedge core_clk);
		chk(tx_abort, 1'b0);
		chk(internal_rst_b, 1'b1);
		@(posedge core_clk);
		supply_ok <= 1'b1;
		repeat (8) @(negedge core_clk);
		chk(tx_enable, 1'b0);
		pulse(0);
		wt(5, 1'b1, 6, c);
		chk(tx_enable, 1'b1);
		wt(1, 1'b1, 1200, c);
		wt(1, 1'b0, 500, c);
		chk_n(c, OD);
		wt(1, 1'b1, 1200, d);
		chk_n(c + d, RI);
		wt(2, 1'b1, 1200, c);
		wt(2, 1'b0, 500, c);
		chk_n(c, OD);
		chk(internal_rst_b, 1'b1);
		for (int k = 0; k < 6; k++) begin
			lf = nx(lf);
			repeat (int'(lf[3:0]) + 1) @(posedge core_clk);
			fault[lf % 3] <= 1'b1;
			wt(3, 1'b0, 10, c);
			chk_n(c, 4);
			@(posedge core_clk);
			fault <= 3'h0;
			wt(3, 1'b1, 12, c);
		end
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk);
			cap_ok[i] <= 1'b0;
			if (i == 0) begin
				pulse(0);
			end
			wt(3, 1'b0, 2100, c);
			chk(internal_rst_b, 1'b0);
			repeat (3) @(negedge core_clk);
			chk(|off, 1'b0);
			@(posedge core_clk);
			cap_ok <= 3'h7;
			wt(3, 1'b1, 12, c);
			chk(tx_enable, 1'b0);
		end
		final_report();
	end
endmodule // tb_supply_monitor_captest
